// file: hdl/mdc_pkg.sv
// Function
// - charge, fast, slow, then charge next period.
// - unfinished charge continues across period boundary.
// - leave charge only on filtered charge-limit.
// - unfinished fast decay continues into next period.
// - fast to slow on filtered decay-switch.
// - decay-switch ignored during blank, acted after.
// - both comparators pass noise filters first.
// - forward current gate patterns per mode.
// - reverse current swaps diagonals, slow unchanged.
// - dead interval, all off, between patterns.
// - fixed oscillator and chopping period derived.
// - regulation uses only the three modes.
package mdc_pkg;
  // system clock rate
  localparam int SYS_MHZ = 250;
  localparam int SYS_HZ = 250_000_000;
  // internal oscillator and chopping frequencies
  localparam int OSC_HZ = 1_080_000;
  localparam int CHOP_HZ = 67_500;
  // system cycles per oscillator tick, rounded down
  localparam int OSC_DIV = SYS_HZ / OSC_HZ;
  // oscillator ticks per chopping period
  localparam int CHOP_RATIO = OSC_HZ / CHOP_HZ;
  // dead interval, least time, rounded up
  localparam int DEAD_NS = 100;
  localparam int DEAD_CYC = (DEAD_NS * SYS_MHZ + 999) / 1000;
  // noise filter stable time, least time, rounded up
  localparam int FILT_NS = 200;
  localparam int FILT_CYC = (FILT_NS * SYS_MHZ + 999) / 1000;
  // decay blanking length in oscillator ticks
  localparam int BLANK_TICKS = 2;
  // gate vector bit positions
  localparam int GATE_W = 4;
  localparam int G_HS1 = 0;
  localparam int G_HS2 = 1;
  localparam int G_LS1 = 2;
  localparam int G_LS2 = 3;
  // gate patterns {ls2, ls1, hs2, hs1}
  localparam logic [3:0] PAT_OFF = 4'h0;
  localparam logic [3:0] PAT_DIAG_A = 4'h9; // hs1 + ls2
  localparam logic [3:0] PAT_DIAG_B = 4'h6; // hs2 + ls1
  localparam logic [3:0] PAT_LOWS = 4'hc; // ls1 + ls2
  // bridge modes
  typedef enum logic [1:0] {
    MDC_CHARGE = 2'b00,
    MDC_FAST = 2'b01,
    MDC_SLOW = 2'b10
  } mdc_mode_t;
  // gate pattern for a mode and current direction
  function automatic logic [3:0] mdc_pattern(input mdc_mode_t m, input logic rev);
    logic [3:0] p;
    p = PAT_OFF;
    unique case (m)
      MDC_CHARGE: p = rev ? PAT_DIAG_B : PAT_DIAG_A;
      MDC_FAST: p = rev ? PAT_DIAG_A : PAT_DIAG_B;
      MDC_SLOW: p = PAT_LOWS;
      default: p = PAT_OFF;
    endcase
    return p;
  endfunction
endpackage

// file: hdl/mdc_chopper.sv
// per-channel mixed decay chopper with bridge gate drive
module mdc_chopper #(
  parameter int OSC_DIV = mdc_pkg::OSC_DIV,
  parameter int CHOP_RATIO = mdc_pkg::CHOP_RATIO,
  parameter int BLANK_TICKS = mdc_pkg::BLANK_TICKS,
  parameter int DEAD_CYC = mdc_pkg::DEAD_CYC,
  parameter int FILT_CYC = mdc_pkg::FILT_CYC
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic CHG_LIMIT_I,
  input wire logic DECAY_SW_I,
  input wire logic DIR_REV_I,
  output logic HS1_O,
  output logic HS2_O,
  output logic LS1_O,
  output logic LS2_O,
  output logic [1:0] MODE_O
);
  localparam int OW = $clog2(OSC_DIV + 1);
  localparam int CW = $clog2(CHOP_RATIO + 1);
  localparam int BW = $clog2(BLANK_TICKS + 1);
  localparam int DW = $clog2(DEAD_CYC + 1);
  localparam int FW = $clog2(FILT_CYC + 1);
  localparam int NPIN = 3;

  // pin synchroniser stages and accepted levels
  logic [NPIN-1:0] s1_r, s2_r, s3_r, acc_r;
  // filtered comparator levels, bit 0 charge limit, bit 1 decay switch
  logic [1:0] flt_w;
  logic [FW-1:0] fcnt_w [2];
  logic chg_flt, dec_flt, dir_rev;
  // oscillator and chopping dividers
  logic [OW-1:0] osc_cnt_r;
  logic [CW-1:0] chop_cnt_r;
  logic osc_tick, chop_tick;
  // mode machine and blanking
  mdc_pkg::mdc_mode_t mode_r, mode_nxt;
  logic [BW-1:0] blank_r;
  logic blank_done;
  // gate drive with dead interval
  logic [3:0] gate_r, tgt_w, cur_r;
  logic [DW-1:0] dead_r;
  logic dead_busy_r;

  // three-stage sync, change accepted when stages two and three agree
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      acc_r <= '0;
    end else begin
      s1_r <= {DIR_REV_I, DECAY_SW_I, CHG_LIMIT_I};
      s2_r <= s1_r;
      s3_r <= s2_r;
      // stages agree: take their level; stages differ: hold
      acc_r <= (s2_r & s3_r) | (acc_r & (s2_r ^ s3_r));
    end
  end

  // noise filters: level must hold for FILT_CYC cycles
  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic [FW-1:0] cnt_r; // cycles the new level has held
    logic lvl_r; // filtered level
    always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
        cnt_r <= '0;
        lvl_r <= 1'b0;
      end else if (acc_r[g] == lvl_r) begin
        cnt_r <= '0; // no pending change
      end else if (cnt_r == FW'(FILT_CYC - 1)) begin
        cnt_r <= '0;
        lvl_r <= acc_r[g];
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
    assign flt_w[g] = lvl_r;
    assign fcnt_w[g] = cnt_r;
  end

  assign chg_flt = flt_w[0];
  assign dec_flt = flt_w[1];
  assign dir_rev = acc_r[2];

  // oscillator tick from the system clock
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      osc_cnt_r <= '0;
    end else if (osc_tick) begin
      osc_cnt_r <= '0;
    end else begin
      osc_cnt_r <= osc_cnt_r + 1'b1;
    end
  end
  assign osc_tick = (osc_cnt_r == OW'(OSC_DIV - 1));

  // chopping period as a fixed divide of the oscillator
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      chop_cnt_r <= '0;
    end else if (chop_tick) begin
      chop_cnt_r <= '0;
    end else if (osc_tick) begin
      chop_cnt_r <= chop_cnt_r + 1'b1;
    end
  end
  assign chop_tick = osc_tick && (chop_cnt_r == CW'(CHOP_RATIO - 1));

  // next mode
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      mdc_pkg::MDC_CHARGE: begin
        // period tick does not restart an unfinished charge
        if (chg_flt) mode_nxt = mdc_pkg::MDC_FAST;
      end
      mdc_pkg::MDC_FAST: begin
        // switch waits for blanking, period tick ignored
        if (blank_done && dec_flt) mode_nxt = mdc_pkg::MDC_SLOW;
      end
      mdc_pkg::MDC_SLOW: begin
        if (chop_tick) mode_nxt = mdc_pkg::MDC_CHARGE;
      end
      default: mode_nxt = mdc_pkg::MDC_CHARGE;
    endcase
  end

  // mode register
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      mode_r <= mdc_pkg::MDC_CHARGE;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // blanking counter, loaded on fast entry, counts oscillator ticks
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      blank_r <= '0;
    end else if (mode_r != mdc_pkg::MDC_FAST && mode_nxt == mdc_pkg::MDC_FAST) begin
      blank_r <= BW'(BLANK_TICKS);
    end else if (osc_tick && blank_r != '0) begin
      blank_r <= blank_r - 1'b1;
    end
  end
  assign blank_done = (blank_r == '0);

  // target gate pattern
  assign tgt_w = mdc_pkg::mdc_pattern(mode_r, dir_rev);

  // gate drive: all off for DEAD_CYC before any new pattern
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      gate_r <= mdc_pkg::PAT_OFF;
      cur_r <= mdc_pkg::PAT_OFF;
      dead_r <= '0;
      dead_busy_r <= 1'b0;
    end else if (dead_busy_r) begin
      if (dead_r == DW'(1)) begin
        gate_r <= tgt_w;
        cur_r <= tgt_w;
        dead_busy_r <= 1'b0;
      end else begin
        dead_r <= dead_r - 1'b1;
      end
    end else if (tgt_w != cur_r) begin
      gate_r <= mdc_pkg::PAT_OFF;
      dead_r <= DW'(DEAD_CYC);
      dead_busy_r <= 1'b1;
    end
  end

  assign HS1_O = gate_r[mdc_pkg::G_HS1];
  assign HS2_O = gate_r[mdc_pkg::G_HS2];
  assign LS1_O = gate_r[mdc_pkg::G_LS1];
  assign LS2_O = gate_r[mdc_pkg::G_LS2];
  assign MODE_O = mode_r;

  // helper: mode and direction that produced the applied pattern
  logic [1:0] app_mode_r;
  logic app_rev_r;
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      app_mode_r <= 2'h0;
      app_rev_r <= 1'b0;
    end else if (dead_busy_r && dead_r == DW'(1)) begin
      app_mode_r <= mode_r;
      app_rev_r <= dir_rev;
    end
  end

  // helper: cycles since the last chopping tick
  localparam int PER_CYC = OSC_DIV * CHOP_RATIO;
  localparam int PW = $clog2(PER_CYC + 1);
  logic [PW-1:0] chop_gap_r;
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      chop_gap_r <= '0;
    end else if (chop_tick) begin
      chop_gap_r <= '0;
    end else begin
      chop_gap_r <= chop_gap_r + 1'b1;
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  // fast entry seen as charge then fast
  sequence s_fast_entry;
    mode_r == mdc_pkg::MDC_CHARGE ##1 mode_r == mdc_pkg::MDC_FAST;
  endsequence

  no_shoot_a: assert property (!(HS1_O && LS1_O) && !(HS2_O && LS2_O))
    else $error("high and low side on together");
  dead_gap_a: assert property ($changed(gate_r) && gate_r != mdc_pkg::PAT_OFF
    |-> $past(gate_r) == mdc_pkg::PAT_OFF && $past(gate_r, DEAD_CYC) == mdc_pkg::PAT_OFF)
    else $error("new pattern without full dead interval");
  charge_exit_a: assert property (mode_r == mdc_pkg::MDC_CHARGE && !chg_flt
    |=> mode_r == mdc_pkg::MDC_CHARGE)
    else $error("charge left without charge limit");
  charge_hold_a: assert property (mode_r == mdc_pkg::MDC_CHARGE && chop_tick
    |=> mode_r == ($past(chg_flt) ? mdc_pkg::MDC_FAST : mdc_pkg::MDC_CHARGE))
    else $error("charge restarted at period boundary");
  fast_hold_a: assert property (mode_r == mdc_pkg::MDC_FAST && !dec_flt
    |=> mode_r == mdc_pkg::MDC_FAST)
    else $error("fast decay left without decay switch");
  blank_start_a: assert property (s_fast_entry |-> blank_r == BW'(BLANK_TICKS))
    else $error("blanking not started on fast entry");
  blank_hold_a: assert property (mode_r == mdc_pkg::MDC_FAST && !blank_done
    |=> mode_r == mdc_pkg::MDC_FAST)
    else $error("fast decay left inside blanking");
  fast_slow_a: assert property (mode_r == mdc_pkg::MDC_FAST && blank_done && dec_flt
    |=> mode_r == mdc_pkg::MDC_SLOW)
    else $error("fast to slow switch missed");
  slow_charge_a: assert property (mode_r == mdc_pkg::MDC_SLOW && chop_tick
    |=> mode_r == mdc_pkg::MDC_CHARGE)
    else $error("slow did not return to charge at period");
  legal_mode_a: assert property (mode_r inside {mdc_pkg::MDC_CHARGE, mdc_pkg::MDC_FAST,
    mdc_pkg::MDC_SLOW})
    else $error("illegal bridge mode");
  gate_map_a: assert property (!dead_busy_r && gate_r != mdc_pkg::PAT_OFF
    |-> gate_r == mdc_pkg::mdc_pattern(mdc_pkg::mdc_mode_t'(app_mode_r), app_rev_r))
    else $error("gate pattern does not match mode and direction");
  filt_len_a: assert property ($changed(chg_flt) |-> $past(fcnt_w[0]) == FW'(FILT_CYC - 1))
    else $error("charge limit filter passed early");
  chop_len_a: assert property (chop_tick |-> chop_gap_r == PW'(PER_CYC - 1))
    else $error("chopping tick off the oscillator divide");
endmodule

// file: tb/mdc_winding.sv
// winding seen through the bridge: current rises in charge, falls in decay
module mdc_winding (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hs1_i,
  input wire logic hs2_i,
  input wire logic ls1_i,
  input wire logic ls2_i,
  input wire logic rev_i,
  input wire logic glitch_i,
  input wire logic [31:0] up_i,
  input wire logic [31:0] dn_i,
  output logic chg_limit_o,
  output logic decay_sw_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cur_r; // winding current, arbitrary units
  logic diag_a; // first high side with second low side
  logic diag_b; // second high side with first low side
  assign diag_a = hs1_i & ls2_i;
  assign diag_b = hs2_i & ls1_i;
  // charge adds, fast removes hard, slow leaks; dead time holds current
  always @(posedge clk_i) begin
    if (rst_i) begin
      cur_r <= 0;
    end else if (rev_i ? diag_b : diag_a) begin
      cur_r <= cur_r + int'(up_i);
    end else if (rev_i ? diag_a : diag_b) begin
      cur_r <= (cur_r > int'(dn_i)) ? cur_r - int'(dn_i) : 0;
    end else if (ls1_i & ls2_i & (cur_r > 0)) begin
      cur_r <= cur_r - 1;
    end
  end
  // comparators; noise spike only when a scenario asks
  assign chg_limit_o = (cur_r >= 1000) | glitch_i;
  assign decay_sw_o = cur_r <= 950;
endmodule

// file: tb/tb_mdc_chopper.sv
// chopper bench against a behavioural winding
module tb_mdc_chopper;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 8; // shortened oscillator divide
  localparam int PERIOD = DIV * 8; // chop period in cycles
  localparam int DEAD = 2; // shortened dead interval
  localparam int BLANK = 4; // blanking long enough to outlast the filter path
  localparam int FILT = 4; // filter long enough to drop a short spike
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rev = 1'b0;
  logic glitch = 1'b0;
  int up = 0; // charge slope
  int dn = 0; // fast decay slope
  logic chg, dec, hs1, hs2, ls1, ls2;
  logic [1:0] mode;
  logic [3:0] gates;
  logic [3:0] prev_g;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int zero_run = 0;
  always #2 clk = ~clk;
  assign gates = {ls2, ls1, hs2, hs1};
  mdc_chopper #(.OSC_DIV(DIV), .CHOP_RATIO(8), .BLANK_TICKS(BLANK), .DEAD_CYC(DEAD),
    .FILT_CYC(FILT)) mdc_chopper_i (.SYS_CLK_I(clk), .RST_I(rst), .CHG_LIMIT_I(chg),
    .DECAY_SW_I(dec), .DIR_REV_I(rev), .HS1_O(hs1), .HS2_O(hs2), .LS1_O(ls1),
    .LS2_O(ls2), .MODE_O(mode));
  mdc_winding mdc_winding_i (.clk_i(clk), .rst_i(rst), .hs1_i(hs1), .hs2_i(hs2),
    .ls1_i(ls1), .ls2_i(ls2), .rev_i(rev), .glitch_i(glitch), .up_i(up), .dn_i(dn),
    .chg_limit_o(chg), .decay_sw_o(dec));
  // compare and count
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // expected gates: diagonal by mode and direction, lows in slow
  function automatic logic [3:0] exp_pat(input logic [1:0] m);
    if (m == 2'h2) return 4'hc;
    return ((m == 2'h0) ^ rev) ? 4'h9 : 4'h6;
  endfunction
  // watchdog plus shoot-through watch every falling edge
  always @(negedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      report_and_stop();
    end else begin
      if (!rst) begin
        check(4'(gates inside {4'h0, 4'h9, 4'h6, 4'hc}), 4'h1);
        if (gates != 4'h0 && gates != prev_g) begin
          check(4'(zero_run >= DEAD), 4'h1);
        end
      end
      zero_run = (gates == 4'h0) ? zero_run + 1 : 0;
      prev_g = gates;
    end
  end
  // reset both sides and set winding slopes
  task automatic do_reset(input logic r, input int u, input int d);
    @(negedge clk);
    rst = 1'b1;
    rev = r;
    up = u;
    dn = d;
    repeat (20) @(negedge clk);
    rst = 1'b0;
  endtask
  // bounded wait for a mode, then the settled gate pattern
  task automatic step_to(input logic [1:0] m, input int lo, input int hi);
    int n;
    n = 0;
    while (mode !== m && n < hi) begin
      @(negedge clk);
      n++;
    end
    check(4'(n >= lo), 4'h1);
    check({2'h0, mode}, {2'h0, m});
    repeat (DEAD + 3) @(negedge clk);
    if (mode === m) begin
      check(gates, exp_pat(m));
    end
  endtask
  // plain forward period and the next
  task automatic fwd_cycle();
    do_reset(1'b0, 50, 10);
    step_to(2'h1, 20, 300);
    step_to(2'h2, 11, 300);
    step_to(2'h0, 1, PERIOD + 5);
    step_to(2'h1, 1, 300);
  endtask
  // charge outlasts two periods
  task automatic slow_charge();
    do_reset(1'b0, 1, 10);
    step_to(2'h1, 2 * PERIOD, 1500);
    step_to(2'h2, 11, 300);
  endtask
  // fast decay outlasts two periods
  task automatic slow_fast();
    do_reset(1'b0, 50, 1);
    step_to(2'h1, 20, 300);
    step_to(2'h2, 2 * PERIOD, 1000);
  endtask
  // reverse, decay crossed inside blanking
  task automatic short_blank();
    do_reset(1'b1, 50, 400);
    step_to(2'h1, 20, 300);
    // crossing lands early; slow may not start before blanking has run out
    step_to(2'h2, (BLANK - 1) * DIV + 1 - (DEAD + 3), 30);
    step_to(2'h0, 1, PERIOD + 5);
  endtask
  // spike shorter than the filter on the charge limit is dropped
  task automatic glitch_reject();
    do_reset(1'b0, 0, 0);
    repeat (10) @(negedge clk);
    glitch = 1'b1;
    repeat (FILT - 1) @(negedge clk);
    glitch = 1'b0;
    repeat (30) @(negedge clk);
    check({2'h0, mode}, 4'h0);
  endtask
  // main sequence
  initial begin
    fwd_cycle();
    slow_charge();
    slow_fast();
    short_blank();
    glitch_reject();
    report_and_stop();
  end
endmodule
